// ===== design/itf_pkg.sv
// Constants shared by the image trailer and frame counter block.
package itf_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] ITF_A_CTRL      = 8'h00;
    localparam logic [7:0] ITF_A_ITEM_SEL  = 8'h04;
    localparam logic [7:0] ITF_A_ITEM_EN   = 8'h08;
    localparam logic [7:0] ITF_A_UNIT_SEL  = 8'h0c;
    localparam logic [7:0] ITF_A_EVT_SRC   = 8'h10;
    localparam logic [7:0] ITF_A_CLR_SRC   = 8'h14;
    localparam logic [7:0] ITF_A_CLR_CMD   = 8'h18;
    localparam logic [7:0] ITF_A_FRAME_CNT = 8'h1c;
    localparam logic [7:0] ITF_A_TRIG_CNT  = 8'h20;
    localparam logic [7:0] ITF_A_DESC_BASE = 8'h24;
    localparam logic [7:0] ITF_A_DESC_LAST = 8'h3c;

    // Field positions.
    localparam int ITF_B_MASTER = 0;
    localparam int ITF_B_KIND   = 1;

    // Trailer item codes for trailer_item_select.
    localparam logic ITF_ITEM_FRAME = 1'b0;
    localparam logic ITF_ITEM_TRIG  = 1'b1;

    // Counter unit codes for count_unit_select.
    localparam logic [1:0] ITF_UNIT_TRIG  = 2'h1;
    localparam logic [1:0] ITF_UNIT_FRAME = 2'h2;

    // Counting event codes for count_event_source.
    localparam logic [1:0] ITF_EVT_OFF   = 2'h0;
    localparam logic [1:0] ITF_EVT_TRIG  = 2'h1;
    localparam logic [1:0] ITF_EVT_FRAME = 2'h2;

    // Codes for count_clear_source.
    localparam logic [1:0] ITF_CLR_OFF   = 2'h0;
    localparam logic [1:0] ITF_CLR_LINE1 = 2'h1;
    localparam logic [1:0] ITF_CLR_LINE2 = 2'h2;
    localparam logic [1:0] ITF_CLR_SW    = 2'h3;

    // Trailer word indices.
    localparam logic [3:0] ITF_IDX_DESC0 = 4'h0;
    localparam logic [3:0] ITF_IDX_DESCN = 4'h6;
    localparam logic [3:0] ITF_IDX_FRAME = 4'h7;
    localparam logic [3:0] ITF_IDX_TRIG  = 4'h8;

    // Values after reset.
    localparam logic [31:0] ITF_CNT_RESET  = 32'h0;
    localparam logic [31:0] ITF_WORD_RESET = 32'h0;

    // Values of stream_content_kind.
    localparam logic ITF_KIND_IMAGE = 1'b0;
    localparam logic ITF_KIND_CHUNK = 1'b1;

    typedef enum logic [0:0] {
        ITF_ST_PASS  = 1'b0,
        ITF_ST_TRAIL = 1'b1
    } itf_state_e;

endpackage

// ===== design/itf_top.sv
// Image stream trailer appender with frame and trigger counters.
`timescale 1ns/1ps

module itf_top
    import itf_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              frame_begin_event,
    input  wire logic              frame_trigger,
    input  wire logic              clear_line1,
    input  wire logic              clear_line2,
    input  wire logic              s_valid,
    output logic                   s_ready,
    input  wire logic [DATA_W-1:0] s_data,
    input  wire logic              s_last,
    output logic                   m_valid,
    input  wire logic              m_ready,
    output logic [DATA_W-1:0]      m_data,
    output logic                   m_last,
    output logic                   stream_content_kind
);

    // Bus address phase capture.
    logic        wr_q;
    logic [7:0]  waddr_q;
    logic [31:0] rdata_q;

    // Configuration.
    logic        master_q;
    logic        item_sel_q;
    logic        frame_en_q;
    logic        trig_en_q;
    logic [1:0]  unit_sel_q;
    logic [1:0]  evt_q [2];
    logic [1:0]  clr_q [2];
    logic [31:0] desc_q [7];

    // Counters, index 0 the trigger unit and 1 the frame unit.
    logic [31:0] cnt_q [2];
    logic [31:0] frame_snap_q;

    // Pin synchronisers and edge memory.
    logic [1:0]  l1_sync_q;
    logic [1:0]  l2_sync_q;
    logic        l1_prev_q;
    logic        l2_prev_q;

    // Stream path.
    itf_state_e        st_q;
    logic [3:0]        idx_q;
    logic              t_frame_q;
    logic              t_trig_q;
    logic [31:0]       t_fcnt_q;
    logic [31:0]       t_tcnt_q;
    logic              out_v_q;
    logic [DATA_W-1:0] out_d_q;
    logic              out_l_q;

    // Descriptor words sit on aligned addresses from base to last.
    function automatic logic is_desc(input logic [7:0] a);
        return a >= ITF_A_DESC_BASE && a <= ITF_A_DESC_LAST &&
               a[1:0] == 2'h0;
    endfunction

    function automatic logic [2:0] desc_slot(input logic [7:0] a);
        return 3'((a - ITF_A_DESC_BASE) >> 2);
    endfunction

    // Unmapped and unaligned addresses read as zero.
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0;
        case (a)
            ITF_A_CTRL: begin
                w[ITF_B_MASTER] = master_q;
                w[ITF_B_KIND]   = stream_content_kind;
            end
            ITF_A_ITEM_SEL:  w[0] = item_sel_q;
            ITF_A_ITEM_EN:   w[0] = item_sel_q ? trig_en_q : frame_en_q;
            ITF_A_UNIT_SEL:  w[1:0] = unit_sel_q;
            ITF_A_EVT_SRC:   w[1:0] = evt_q[unit_sel_q[1]];
            ITF_A_CLR_SRC:   w[1:0] = clr_q[unit_sel_q[1]];
            ITF_A_FRAME_CNT: w = cnt_q[1];
            ITF_A_TRIG_CNT:  w = cnt_q[0];
            default: begin
                if (is_desc(a)) begin
                    w = desc_q[desc_slot(a)];
                end
            end
        endcase
        return w;
    endfunction

    // Bus decode; single-word transfers, zero wait states, always OKAY.
    // Read data is fetched in the address phase, so a read that follows
    // a write to the same register needs one idle cycle in between.
    wire       addr_ph   = hsel && htrans[1] && hready;
    wire       wr_now    = wr_q && hready;
    wire       unit_ok   = unit_sel_q == ITF_UNIT_TRIG ||
                           unit_sel_q == ITF_UNIT_FRAME;
    wire       unit_idx  = unit_sel_q[1];
    wire       we_ctrl   = wr_now && waddr_q == ITF_A_CTRL;
    wire       we_isel   = wr_now && waddr_q == ITF_A_ITEM_SEL;
    wire       we_ien    = wr_now && waddr_q == ITF_A_ITEM_EN;
    wire       we_usel   = wr_now && waddr_q == ITF_A_UNIT_SEL;
    wire       we_evt    = wr_now && waddr_q == ITF_A_EVT_SRC && unit_ok;
    wire       we_clr    = wr_now && waddr_q == ITF_A_CLR_SRC && unit_ok;
    wire       sw_cmd    = wr_now && waddr_q == ITF_A_CLR_CMD &&
                           unit_ok && hwdata[0];
    wire       we_desc   = wr_now && is_desc(waddr_q);
    wire [2:0] desc_widx = desc_slot(waddr_q);
    wire       master_d  = we_ctrl ? hwdata[ITF_B_MASTER] : master_q;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h0;
            rdata_q <= ITF_WORD_RESET;
        end else if (hready) begin
            wr_q    <= addr_ph && hwrite;
            waddr_q <= haddr[7:0];
            if (addr_ph && !hwrite) begin
                rdata_q <= rd_word(haddr[7:0]);
            end
        end
    end

    // The descriptor item needs no enable of its own.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            master_q   <= 1'b0;
            item_sel_q <= ITF_ITEM_FRAME;
            frame_en_q <= 1'b0;
            trig_en_q  <= 1'b0;
            unit_sel_q <= ITF_UNIT_FRAME;
        end else begin
            master_q <= master_d;
            if (we_isel) begin
                item_sel_q <= hwdata[0];
            end
            if (we_usel) begin
                unit_sel_q <= hwdata[1:0];
            end
            if (!master_d) begin
                frame_en_q <= 1'b0;
                trig_en_q  <= 1'b0;
            end else if (we_ien && master_q) begin
                if (item_sel_q == ITF_ITEM_TRIG) begin
                    trig_en_q <= hwdata[0];
                end else begin
                    frame_en_q <= hwdata[0];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < 7; i++) begin
                desc_q[i] <= ITF_WORD_RESET;
            end
        end else if (we_desc) begin
            desc_q[desc_widx] <= hwdata;
        end
    end

    // Pins are asynchronous; the first stage feeds only the second.
    // The edge memory resets low to match the idle level of the pins.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            l1_sync_q <= 2'h0;
            l2_sync_q <= 2'h0;
            l1_prev_q <= 1'b0;
            l2_prev_q <= 1'b0;
        end else begin
            l1_sync_q <= {l1_sync_q[0], clear_line1};
            l2_sync_q <= {l2_sync_q[0], clear_line2};
            l1_prev_q <= l1_sync_q[1];
            l2_prev_q <= l2_sync_q[1];
        end
    end

    wire l1_rise = l1_sync_q[1] && !l1_prev_q;
    wire l2_rise = l2_sync_q[1] && !l2_prev_q;

    // A clear in the same cycle as a count event wins over the count.
    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            wire [1:0] evt_rst = (u == 1) ? ITF_EVT_FRAME : ITF_EVT_TRIG;
            wire ev = (evt_q[u] == ITF_EVT_FRAME && frame_begin_event) ||
                      (evt_q[u] == ITF_EVT_TRIG && frame_trigger);
            wire sel_u = unit_idx == 1'(u);
            wire clr = (clr_q[u] == ITF_CLR_LINE1 && l1_rise) ||
                       (clr_q[u] == ITF_CLR_LINE2 && l2_rise) ||
                       (clr_q[u] == ITF_CLR_SW && sw_cmd && sel_u);
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    evt_q[u] <= evt_rst;
                    clr_q[u] <= ITF_CLR_OFF;
                    cnt_q[u] <= ITF_CNT_RESET;
                end else begin
                    if (we_evt && sel_u) begin
                        evt_q[u] <= hwdata[1:0];
                    end
                    if (we_clr && sel_u) begin
                        clr_q[u] <= hwdata[1:0];
                    end
                    if (clr) begin
                        cnt_q[u] <= ITF_CNT_RESET;
                    end else if (ev) begin
                        // All ones rolls over to zero by plain overflow.
                        cnt_q[u] <= cnt_q[u] + 32'h1;
                    end
                end
            end
        end
    endgenerate

    // The frame carries the count held before its own increment.
    wire frame_ev = evt_q[1] == ITF_EVT_FRAME && frame_begin_event;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            frame_snap_q <= ITF_CNT_RESET;
        end else if (frame_ev) begin
            frame_snap_q <= cnt_q[1];
        end
    end

    // Stream path: one output register, image first, then the trailer.
    wire        slot_free = !out_v_q || m_ready;
    wire        in_pass   = st_q == ITF_ST_PASS;
    wire        take_img  = s_valid && s_ready;
    wire        go_trail  = take_img && s_last && master_q;
    wire [3:0]  last_idx  = t_trig_q ? ITF_IDX_TRIG :
                            t_frame_q ? ITF_IDX_FRAME : ITF_IDX_DESCN;
    // Without the frame count item the walk jumps from the last
    // descriptor word straight to the trigger count.
    wire [3:0]  next_idx  = (idx_q == ITF_IDX_DESCN && !t_frame_q) ?
                            ITF_IDX_TRIG : idx_q + 4'h1;
    wire        trail_end = idx_q == last_idx;
    wire [31:0] trail_w   = (idx_q == ITF_IDX_TRIG)  ? t_tcnt_q :
                            (idx_q == ITF_IDX_FRAME) ? t_fcnt_q :
                            desc_q[idx_q[2:0]];

    assign s_ready = in_pass && slot_free;
    assign m_valid = out_v_q;
    assign m_data  = out_d_q;
    assign m_last  = out_l_q;
    assign stream_content_kind = master_q ? ITF_KIND_CHUNK
                                          : ITF_KIND_IMAGE;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_q      <= ITF_ST_PASS;
            idx_q     <= ITF_IDX_DESC0;
            t_frame_q <= 1'b0;
            t_trig_q  <= 1'b0;
            t_fcnt_q  <= ITF_CNT_RESET;
            t_tcnt_q  <= ITF_CNT_RESET;
        end else begin
            // Enables and counts are latched with the image last beat, so
            // a change during a trailer only affects the next image.
            unique case (st_q)
                ITF_ST_PASS: begin
                    if (go_trail) begin
                        st_q      <= ITF_ST_TRAIL;
                        idx_q     <= ITF_IDX_DESC0;
                        t_frame_q <= frame_en_q;
                        t_trig_q  <= trig_en_q;
                        t_fcnt_q  <= frame_snap_q;
                        t_tcnt_q  <= cnt_q[0];
                    end
                end
                ITF_ST_TRAIL: begin
                    if (slot_free) begin
                        idx_q <= next_idx;
                        if (trail_end) begin
                            st_q <= ITF_ST_PASS;
                        end
                    end
                end
            endcase
        end
    end

    // Image last closes the unit only when no trailer follows.
    // A stalled beat stays put until the host takes it.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_v_q <= 1'b0;
            out_d_q <= '0;
            out_l_q <= 1'b0;
        end else if (in_pass && take_img) begin
            out_v_q <= 1'b1;
            out_d_q <= s_data;
            out_l_q <= s_last && !master_q;
        end else if (!in_pass && slot_free) begin
            out_v_q <= 1'b1;
            out_d_q <= DATA_W'(trail_w);
            out_l_q <= trail_end;
        end else if (m_ready) begin
            out_v_q <= 1'b0;
        end
    end

endmodule

// ===== testbench/itf_monitor.sv
// Concurrent checks on the ports of the trailer block.
`timescale 1ns/1ps
module itf_monitor
    import itf_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [31:0]       hrdata,
    input wire logic              frame_begin_event,
    input wire logic              frame_trigger,
    input wire logic              clear_line1,
    input wire logic              clear_line2,
    input wire logic              s_valid,
    input wire logic              s_ready,
    input wire logic [DATA_W-1:0] s_data,
    input wire logic              s_last,
    input wire logic              m_valid,
    input wire logic              m_ready,
    input wire logic [DATA_W-1:0] m_data,
    input wire logic              m_last,
    input wire logic              stream_content_kind
);
    logic wc_q;
    logic rd_q;
    logic take;
    assign take = hsel && htrans[1] && hready;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wc_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wc_q <= take && hwrite && haddr[7:0] == ITF_A_CTRL;
            rd_q <= take && !hwrite;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus wait or error seen");
    chk_kind_write: assert property (wc_q |=>
        stream_content_kind == $past(hwdata[ITF_B_MASTER]))
        else $error("content kind does not follow master");
    chk_out_hold: assert property (m_valid && !m_ready |=>
        m_valid && $stable(m_data) && $stable(m_last))
        else $error("output beat changed while stalled");
    chk_stall_block: assert property (m_valid && !m_ready |-> !s_ready)
        else $error("input taken while output stalled");
    chk_beat_pass: assert property (s_valid && s_ready |=>
        m_valid && m_data == $past(s_data)
        && m_last == $past(s_last && !stream_content_kind))
        else $error("image beat not passed through");
    chk_trail_len: assert property (
        s_valid && s_ready && s_last && stream_content_kind
        |=> !s_ready [*7])
        else $error("trailer shorter than descriptor");
    chk_trail_end: assert property (
        s_valid && s_ready && s_last && stream_content_kind
        |-> ##[1:1000] m_valid && m_ready && m_last)
        else $error("trailer never closed");
    chk_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (
        take && !hwrite && haddr[7:0] > ITF_A_DESC_LAST |=> hrdata == 0)
        else $error("unmapped read not zero");
endmodule

// ===== testbench/itf_host_model.sv
// Host side receiver that stalls at random and records every beat.
`timescale 1ns/1ps
module itf_host_model (
    input wire logic        clock,
    input wire logic        slow,
    input wire logic        m_valid,
    input wire logic [31:0] m_data,
    input wire logic        m_last,
    output logic            m_ready
);
    logic [32:0] got[$];
    initial m_ready = 1'b0;
    // Stalls are drawn per cycle so the hold logic sees stalls mid-trailer.
    always @(posedge clock) begin
        if (m_valid && m_ready)
            got.push_back({m_last, m_data});
        m_ready <= slow ? 1'($urandom) : 1'b1;
    end
endmodule

// ===== testbench/image_chunk_trailer_frame_counter_tb_top.sv
// Self-checking bench for the trailer and frame counter block.
`timescale 1ns/1ps
module image_chunk_trailer_frame_counter_tb_top
    import itf_pkg::*;
;
    logic        clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
    logic        s_valid, s_ready, s_last, m_valid, m_ready, m_last;
    logic        frame_begin_event, frame_trigger, slow;
    logic        clear_line1, clear_line2, stream_content_kind;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, s_data, m_data, rdv, desc[7];
    int          fails, cmp_count;
    assign hready = hreadyout;
    itf_top DUT (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .frame_begin_event,
        .frame_trigger, .clear_line1, .clear_line2, .s_valid, .s_ready,
        .s_data, .s_last, .m_valid, .m_ready, .m_data, .m_last,
        .stream_content_kind);
    itf_host_model host (.clock, .slow, .m_valid, .m_data, .m_last,
        .m_ready);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic tally_and_finish;
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Ready is sampled at the falling edge so the rising edge never races.
    task automatic go(input bit bus);
        int  n;
        bit  ok;
        n = 0;
        do begin
            @(negedge clock);
            ok = bus ? hready : s_ready;
            rdv = hrdata;
            @(posedge clock);
            n++;
        end while (!ok && n < 300);
        if (!ok) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        go(1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        go(1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), {1'b0, rdv}, {1'b0, e});
    endtask
    task automatic pulse(input bit t);
        @(posedge clock);
        frame_trigger <= t;
        frame_begin_event <= !t;
        @(posedge clock);
        frame_trigger <= 1'b0;
        frame_begin_event <= 1'b0;
    endtask
    task automatic image(input int n, input bit m, fe, te,
                         input logic [31:0] fw, tw);
        logic [32:0] exp[$];
        logic [31:0] d;
        int          k;
        host.got.delete();
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            exp.push_back({1'b0, d});
            s_valid <= 1'b1;
            s_data <= d;
            s_last <= (i == n - 1);
            go(0);
        end
        s_valid <= 1'b0;
        if (m) foreach (desc[i]) exp.push_back({1'b0, desc[i]});
        if (m && fe) exp.push_back({1'b0, fw});
        if (m && te) exp.push_back({1'b0, tw});
        exp[$][32] = 1'b1;
        for (k = 0; k < 500 && host.got.size() < exp.size(); k++)
            @(posedge clock);
        chk("beats", host.got.size(), exp.size());
        foreach (exp[i]) chk("beat", host.got[i], exp[i]);
        if (k == 500) tally_and_finish();
    endtask
    initial begin
        {nrst, hsel, hwrite, htrans, haddr, hwdata, s_valid, s_last} = '0;
        {frame_begin_event, frame_trigger, clear_line1, clear_line2} = '0;
        {s_data, slow, fails, cmp_count} = '0;
        hsize = 3'h2;
        rdv = $urandom(32'h147f);
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rchk(ITF_A_CTRL, 32'h0);
        rchk(ITF_A_FRAME_CNT, ITF_CNT_RESET);
        rchk(8'h40, 32'h0);
        bus(1'b1, ITF_A_ITEM_EN, 32'h1);
        rchk(ITF_A_ITEM_EN, 32'h0);
        foreach (desc[i]) begin
            desc[i] = $urandom;
            bus(1'b1, ITF_A_DESC_BASE + 8'(4 * i), desc[i]);
        end
        bus(1'b1, ITF_A_CTRL, 32'h1);
        rchk(ITF_A_CTRL, 32'h3);
        bus(1'b1, ITF_A_UNIT_SEL, {30'h0, ITF_UNIT_FRAME});
        bus(1'b1, ITF_A_EVT_SRC, {30'h0, ITF_EVT_FRAME});
        bus(1'b1, ITF_A_ITEM_EN, 32'h1);
        bus(1'b1, ITF_A_ITEM_SEL, 32'h1);
        bus(1'b1, ITF_A_ITEM_EN, 32'h1);
        for (int f = 0; f < 4; f++) begin
            slow <= f[0];
            pulse(1'b0);
            pulse(1'b1);
            image(1 + $urandom % 6, 1, 1, 1, f, f + 1);
        end
        rchk(ITF_A_FRAME_CNT, 32'h4);
        rchk(ITF_A_TRIG_CNT, 32'h4);
        bus(1'b1, ITF_A_CLR_CMD, 32'h1);
        rchk(ITF_A_FRAME_CNT, 32'h4);
        bus(1'b1, ITF_A_UNIT_SEL, {30'h0, ITF_UNIT_TRIG});
        bus(1'b1, ITF_A_CLR_SRC, {30'h0, ITF_CLR_SW});
        bus(1'b1, ITF_A_CLR_CMD, 32'h1);
        rchk(ITF_A_TRIG_CNT, 32'h0);
        rchk(ITF_A_FRAME_CNT, 32'h4);
        bus(1'b1, ITF_A_UNIT_SEL, {30'h0, ITF_UNIT_FRAME});
        bus(1'b1, ITF_A_CLR_SRC, {30'h0, ITF_CLR_SW});
        bus(1'b1, ITF_A_CLR_CMD, 32'h1);
        rchk(ITF_A_FRAME_CNT, 32'h0);
        // The unselected line is raised first and must leave the count alone.
        for (int s = 1; s < 3; s++) begin
            pulse(1'b0);
            bus(1'b1, ITF_A_CLR_SRC, 32'(s));
            for (int j = 0; j < 2; j++) begin
                {clear_line2, clear_line1} <= 2'(j ? 1 << (s - 1) : 1 << (2 - s));
                repeat (6) @(posedge clock);
                {clear_line2, clear_line1} <= 2'h0;
                rchk(ITF_A_FRAME_CNT, j ? 32'h0 : 32'h1);
            end
        end
        bus(1'b1, ITF_A_CTRL, 32'h0);
        @(negedge clock);
        chk("kind", stream_content_kind, ITF_KIND_IMAGE);
        rchk(ITF_A_ITEM_EN, 32'h0);
        image(3, 0, 0, 0, 0, 0);
        bus(1'b1, ITF_A_CTRL, 32'h1);
        rchk(ITF_A_ITEM_EN, 32'h0);
        image(2, 1, 0, 0, 0, 0);
        pulse(1'b0);
        rchk(ITF_A_FRAME_CNT, 32'h1);
        pulse(1'b1);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rchk(ITF_A_FRAME_CNT, ITF_CNT_RESET);
        rchk(ITF_A_TRIG_CNT, ITF_CNT_RESET);
        rchk(ITF_A_CTRL, 32'h0);
        tally_and_finish();
    end
endmodule
bind itf_top itf_monitor #(.DATA_W(DATA_W)) mon (.clock, .nrst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .frame_begin_event, .frame_trigger, .clear_line1, .clear_line2,
    .s_valid, .s_ready, .s_data, .s_last, .m_valid, .m_ready, .m_data,
    .m_last, .stream_content_kind);
